// ===== hw/calb_params.svh
`ifndef CALB_PARAMS_SVH
`define CALB_PARAMS_SVH

// command codes
`define CALB_CMD_LIMIT         8'h36
`define CALB_CMD_PHASE         8'h37
`define CALB_CMD_REGUL         8'h38

// register widths
`define CALB_LIMIT_W           16
`define CALB_PHASE_W           13
`define CALB_REGUL_W           6

// reset values
`define CALB_LIMIT_RST         16'h0000
`define CALB_PHASE_RST         13'h0000
`define CALB_REGUL_RST         6'h00

// bits held by this bank
`define CALB_LIMIT_MASK        16'h000F
`define CALB_PHASE_MASK        13'h1F43
`define CALB_REGUL_MASK        6'h38

// limit alert bit positions
`define CALB_BIT_HEAT_OVER     3
`define CALB_BIT_RES_OVER      2
`define CALB_BIT_NTC_OVER      1
`define CALB_BIT_NTC_UNDER     0

// charge-regulation indicator bit positions
`define CALB_BIT_ILIM          5
`define CALB_BIT_THERMAL       4
`define CALB_BIT_UVCL          3

`endif

// ===== hw/calb_pkg.sv
package calb_pkg;

   // host command from the serial-port register logic
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] wdata;
   } calb_cmd_t;

   // telemetry readings and programmed limits, two's complement
   typedef struct packed {
      logic signed [15:0] heat;
      logic signed [15:0] heat_hi_lim;
      logic signed [15:0] res;
      logic signed [15:0] res_hi_lim;
      logic signed [15:0] ntc;
      logic signed [15:0] ntc_hi_lim;
      logic signed [15:0] ntc_lo_lim;
   } calb_meas_t;

   // per-alert enable registers held elsewhere
   typedef struct packed {
      logic [15:0] limit;
      logic [12:0] phase;
      logic [5:0]  regul;
   } calb_en_t;

endpackage

// ===== hw/calb_sticky.sv
`timescale 1ns/1ns
`include "calb_params.svh"

module calb_sticky
   import calb_pkg::*;
#(
   parameter int                W      = 16,
   parameter logic [W-1:0]      MASK   = '1,
   parameter logic [W-1:0]      RST    = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // conditions and enables
   input  wire logic [W-1:0] cond,
   input  wire logic [W-1:0] en,
   // host clearing write
   input  wire logic         clr_wr,
   input  wire logic [W-1:0] clr_data,
   // latched alerts
   output logic [W-1:0]      q
);

   logic [W-1:0] keep;
   logic [W-1:0] next_q;

   always_comb begin
      keep = q;
      if (clr_wr) begin
         keep = q & clr_data;
      end
      next_q = ((keep | cond) & en) & MASK;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST;
      end else begin
         q <= next_q;
      end
   end

endmodule // calb_sticky

// ===== hw/calb_top.sv
// What this block does
// - junction temperature above its high limit and enabled sets limit alert bit 3
// - cell resistance above its high limit and enabled sets limit alert bit 2
// - thermistor voltage above its high limit and enabled sets limit alert bit 1
// - thermistor voltage below its low limit and enabled sets limit alert bit 0
// - host writes 0 to clear a bit, 1 elsewhere; only 0 bits clear
// - clearing an alert's enable bit also clears that alert
// - alerts are sticky until cleared by write or by disable
// - 13-bit charger-phase alert register at code 0x37, reset zero, per-bit enables
// - detect-failed phase sets charger-phase alert bit 12
// - battery detection phase sets charger-phase alert bit 11
// - equalize phase sets charger-phase alert bit 10
// - absorb phase sets charger-phase alert bit 9
// - suspended state sets charger-phase alert bit 8
// - bulk cc/cv phase sets bit 6; bits 7 and 5..2 unused
// - missing-battery fault sets charger-phase alert bit 1
// - shorted-battery fault sets bit 0; disabling it clears it
// - 6-bit charge-regulation alert register at code 0x38, reset zero, per-bit enables
// - current-limit loop in control sets regulation alert bit 5
// - thermal regulation in control sets regulation alert bit 4
// - input undervoltage loop in control sets regulation alert bit 3
// - charger-phase indicator is one-hot, same bit codes, reset value suspended
// - regulation indicator is one-hot, active only while charging
// - limit alerts live in 16-bit register at code 0x36, reset zero
`timescale 1ns/1ns
`include "calb_params.svh"

module calb_top
   import calb_pkg::*;
#(
   parameter int LIMIT_W = `CALB_LIMIT_W,
   parameter int PHASE_W = `CALB_PHASE_W,
   parameter int REGUL_W = `CALB_REGUL_W
) (
   // clock and reset
   input  wire logic               CLK_SYS_I,
   input  wire logic               RST_N_I,
   // host register access
   input  wire calb_cmd_t          CMD_I,
   output logic [15:0]             RDATA_O,
   output logic                    RVALID_O,
   output logic                    RHIT_O,
   // monitored conditions
   input  wire calb_meas_t         MEAS_I,
   input  wire logic [PHASE_W-1:0] PHASE_I,
   input  wire logic [REGUL_W-1:0] REGUL_I,
   // per-alert enables
   input  wire calb_en_t           EN_I,
   // latched alerts
   output logic [LIMIT_W-1:0]      LIMIT_ALERT_O,
   output logic [PHASE_W-1:0]      PHASE_ALERT_O,
   output logic [REGUL_W-1:0]      REGUL_ALERT_O
);

   logic [LIMIT_W-1:0] limit_cond;
   logic [PHASE_W-1:0] phase_cond;
   logic [REGUL_W-1:0] regul_cond;
   logic               wr_limit;
   logic               wr_phase;
   logic               wr_regul;
   logic [15:0]        next_rdata;
   logic               next_hit;

   function automatic logic above(input logic signed [15:0] val,
                                  input logic signed [15:0] lim);
      above = val > lim;
   endfunction

   // limit comparisons
   always_comb begin
      limit_cond                      = '0;
      limit_cond[`CALB_BIT_HEAT_OVER] = above(MEAS_I.heat, MEAS_I.heat_hi_lim);
      limit_cond[`CALB_BIT_RES_OVER]  = above(MEAS_I.res, MEAS_I.res_hi_lim);
      limit_cond[`CALB_BIT_NTC_OVER]  = above(MEAS_I.ntc, MEAS_I.ntc_hi_lim);
      limit_cond[`CALB_BIT_NTC_UNDER] = above(MEAS_I.ntc_lo_lim, MEAS_I.ntc);
   end

   // phase indicator maps bit for bit onto the alert register
   assign phase_cond = PHASE_I;
   assign regul_cond = REGUL_I;

   // command decode
   always_comb begin
      wr_limit = 1'b0;
      wr_phase = 1'b0;
      wr_regul = 1'b0;
      if (CMD_I.wr && CMD_I.code == `CALB_CMD_LIMIT) begin
         wr_limit = 1'b1;
      end else if (CMD_I.wr && CMD_I.code == `CALB_CMD_PHASE) begin
         wr_phase = 1'b1;
      end else if (CMD_I.wr && CMD_I.code == `CALB_CMD_REGUL) begin
         wr_regul = 1'b1;
      end
   end

   calb_sticky #(
      .W    (LIMIT_W),
      .MASK (`CALB_LIMIT_MASK),
      .RST  (`CALB_LIMIT_RST)
   ) u_limit (
      .clk      (CLK_SYS_I),
      .rst_n    (RST_N_I),
      .cond     (limit_cond),
      .en       (EN_I.limit),
      .clr_wr   (wr_limit),
      .clr_data (CMD_I.wdata[LIMIT_W-1:0]),
      .q        (LIMIT_ALERT_O)
   );

   calb_sticky #(
      .W    (PHASE_W),
      .MASK (`CALB_PHASE_MASK),
      .RST  (`CALB_PHASE_RST)
   ) u_phase (
      .clk      (CLK_SYS_I),
      .rst_n    (RST_N_I),
      .cond     (phase_cond),
      .en       (EN_I.phase),
      .clr_wr   (wr_phase),
      .clr_data (CMD_I.wdata[PHASE_W-1:0]),
      .q        (PHASE_ALERT_O)
   );

   calb_sticky #(
      .W    (REGUL_W),
      .MASK (`CALB_REGUL_MASK),
      .RST  (`CALB_REGUL_RST)
   ) u_regul (
      .clk      (CLK_SYS_I),
      .rst_n    (RST_N_I),
      .cond     (regul_cond),
      .en       (EN_I.regul),
      .clr_wr   (wr_regul),
      .clr_data (CMD_I.wdata[REGUL_W-1:0]),
      .q        (REGUL_ALERT_O)
   );

   // read mux, unmapped codes read zero
   always_comb begin
      next_rdata = 16'h0000;
      next_hit   = 1'b1;
      if (CMD_I.code == `CALB_CMD_LIMIT) begin
         next_rdata = 16'(LIMIT_ALERT_O);
      end else if (CMD_I.code == `CALB_CMD_PHASE) begin
         next_rdata = 16'(PHASE_ALERT_O);
      end else if (CMD_I.code == `CALB_CMD_REGUL) begin
         next_rdata = 16'(REGUL_ALERT_O);
      end else begin
         next_hit = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O  <= 16'h0000;
         RVALID_O <= 1'b0;
         RHIT_O   <= 1'b0;
      end else begin
         RVALID_O <= CMD_I.rd;
         if (CMD_I.rd) begin
            RDATA_O <= next_rdata;
            RHIT_O  <= next_hit;
         end
      end
   end

endmodule // calb_top

// ===== tb/calb_host.sv
`timescale 1ns/1ns
module calb_host import calb_pkg::*; (
   // host bus
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   output calb_cmd_t        cmd_o
);
   initial cmd_o = '0;
   task automatic clr(input logic [7:0] c, input int b);
      @(posedge clk_i);
      cmd_o <= '{1'b1, 1'b0, c, ~(16'h0001 << b)};
      @(posedge clk_i);
      cmd_o <= '{1'b0, 1'b0, ~c, 16'h0001 << b};
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(posedge clk_i);
      cmd_o <= '{1'b0, 1'b1, c, 16'h0000};
      @(posedge clk_i);
      cmd_o <= '{1'b0, 1'b0, ~c, 16'hFFFF};
      #1 d = rdata_i;
   endtask
endmodule // calb_host

// ===== tb/calb_top_props.sv
`timescale 1ns/1ns
module calb_top_props import calb_pkg::*; (
   // clock, reset, host access
   input wire logic        CLK_SYS_I,
   input wire logic        RST_N_I,
   input wire calb_cmd_t   CMD_I,
   input wire logic [15:0] RDATA_O,
   input wire logic        RVALID_O,
   input wire logic        RHIT_O,
   // conditions, enables, alerts
   input wire logic [12:0] PHASE_I,
   input wire logic [5:0]  REGUL_I,
   input wire calb_en_t    EN_I,
   input wire logic [15:0] LIMIT_ALERT_O,
   input wire logic [12:0] PHASE_ALERT_O,
   input wire logic [5:0]  REGUL_ALERT_O
);
   logic [18:0] hit_set;
   assign hit_set = {PHASE_I & EN_I.phase & 13'h1F43, REGUL_I & EN_I.regul & 6'h38};
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_wr; CMD_I.wr && CMD_I.code == 8'h37; endsequence
   sequence s_rd; CMD_I.rd && CMD_I.code == 8'h37; endsequence
   sequence s_ans; RVALID_O && RHIT_O; endsequence
   a_cond_sets: assert property ($past(RST_N_I) |=>
      ($past(hit_set) & ~{PHASE_ALERT_O, REGUL_ALERT_O}) == '0) else $error("alert not set");
   a_dis_clears: assert property (1 |=> (PHASE_ALERT_O & ~$past(EN_I.phase)) == '0)
      else $error("disabled alert set");
   a_unheld_zero: assert property (LIMIT_ALERT_O[15:4] == '0 && REGUL_ALERT_O[2:0] == '0
      && (PHASE_ALERT_O & 13'h00BC) == '0) else $error("unheld bit set");
   a_sticky_hold: assert property (!CMD_I.wr |=>
      ($past(PHASE_ALERT_O) & $past(EN_I.phase) & ~PHASE_ALERT_O) == '0) else $error("alert lost");
   a_clear_bits: assert property (s_wr |=>
      (PHASE_ALERT_O & ~$past(CMD_I.wdata[12:0]) & ~$past(hit_set[18:6])) == '0)
      else $error("alert not cleared");
   a_keep_ones: assert property (s_wr |=> ($past(PHASE_ALERT_O) & $past(CMD_I.wdata[12:0])
      & $past(EN_I.phase) & ~PHASE_ALERT_O) == '0) else $error("write of one cleared");
   a_read_phase: assert property (s_rd |=> s_ans ##0 RDATA_O == {3'h0, $past(PHASE_ALERT_O)})
      else $error("phase read wrong");
   a_read_miss: assert property (CMD_I.rd && CMD_I.code < 8'h36 |=>
      RVALID_O && !RHIT_O && RDATA_O == '0) else $error("miss read wrong");
endmodule // calb_top_props

bind calb_top calb_top_props calb_top_props_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .CMD_I(CMD_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .RHIT_O(RHIT_O), .PHASE_I(PHASE_I),
   .REGUL_I(REGUL_I), .EN_I(EN_I), .LIMIT_ALERT_O(LIMIT_ALERT_O),
   .PHASE_ALERT_O(PHASE_ALERT_O), .REGUL_ALERT_O(REGUL_ALERT_O));

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench import calb_pkg::*;;
   logic        clk, rst_n;
   calb_cmd_t   cmd;
   calb_meas_t  meas;
   calb_en_t    en;
   logic [12:0] phase, ph_q;
   logic [5:0]  regul, rg_q;
   logic [15:0] lim_q, rdata, d;
   logic        rvalid, rhit;
   int          error_cnt = 0;
   int          check_count = 0;
   calb_top calb_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CMD_I(cmd), .RDATA_O(rdata),
      .RVALID_O(rvalid), .RHIT_O(rhit), .MEAS_I(meas), .PHASE_I(phase),
      .REGUL_I(regul), .EN_I(en),
      .LIMIT_ALERT_O(lim_q), .PHASE_ALERT_O(ph_q), .REGUL_ALERT_O(rg_q));
   calb_host calb_host_i (.clk_i(clk), .rdata_i(rdata), .cmd_o(cmd));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // one limit crossing at a time, equal values must not trip
   task automatic t_limit();
      for (int b = 0; b < 4; b++) begin
         @(posedge clk);
         meas <= {16'h10 + 16'(b == 3), 16'h10, 16'h10 + 16'(b == 2), 16'h10, 16'h10,
                  16'h10 - 16'(b == 1), 16'h10 + 16'(b == 0)};
         @(posedge clk);
         meas <= {7{16'h0010}};
         cyc(2);
         chk("limit", 16'h0001 << b, lim_q);
         calb_host_i.rd(8'h36, d);
         chk("limit read", 16'h0001 << b, d);
         calb_host_i.clr(8'h36, b);
         cyc(0);
         chk("limit clear", 16'h0000, lim_q);
      end
   endtask
   // walk every phase and regulation code, then clear and disable
   task automatic t_phase();
      logic [12:0] c [8] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200,
                             13'h0100, 13'h0040, 13'h0002, 13'h0001};
      logic [18:0] x = '0;
      @(posedge clk);
      en.phase <= 13'h1FFF;
      for (int i = 0; i < 8; i++) begin
         phase <= c[i];
         regul <= 6'h20 >> i;
         x = x | {c[i], (6'h20 >> i) & 6'h38};
         cyc(1);
         chk("phase", {3'h0, x[18:6]}, {3'h0, ph_q});
         chk("regul", {10'h0, x[5:0]}, {10'h0, rg_q});
         @(posedge clk);
      end
      calb_host_i.rd(8'h37, d);
      chk("phase read", 16'h1F43, d);
      chk("read valid", 16'h0001, {15'h0, rvalid});
      chk("read hit", 16'h0001, {15'h0, rhit});
      calb_host_i.rd(8'h38, d);
      chk("regul read", 16'h0038, d);
      chk("regul hit", 16'h0001, {15'h0, rhit});
      calb_host_i.rd(8'h35, d);
      chk("miss read", 16'h0000, d);
      chk("miss hit", 16'h0000, {15'h0, rhit});
      calb_host_i.clr(8'h37, 9);
      cyc(0);
      chk("phase clear", 16'h1D43, {3'h0, ph_q});
      calb_host_i.clr(8'h37, 0);
      cyc(0);
      chk("phase set wins", 16'h1D43, {3'h0, ph_q});
      calb_host_i.clr(8'h38, 4);
      cyc(0);
      chk("regul clear", 16'h0028, {10'h0, rg_q});
      @(posedge clk);
      en.phase[0] <= 1'b0;
      cyc(2);
      chk("phase off", 16'h1D42, {3'h0, ph_q});
   endtask
   // reset in mid-run drops every alert; a condition after release sets again
   task automatic t_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(1);
      chk("mid reset", 16'h0000, lim_q | {3'h0, ph_q} | {10'h0, rg_q});
      @(posedge clk);
      rst_n <= 1'b1;
      phase <= 13'h0100;
      cyc(1);
      chk("after reset", 16'h0100, {3'h0, ph_q});
      chk("after reset rest", 16'h0000, lim_q | {10'h0, rg_q});
   endtask
   initial begin
      rst_n = 1'b0;
      meas = {7{16'h0010}};
      en = {16'hFFFF, 13'h0000, 6'h3F};
      phase = 13'h0100;
      regul = 6'h00;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk("reset", 16'h0000, lim_q | {3'h0, ph_q} | {10'h0, rg_q});
      t_limit();
      t_phase();
      t_reset();
      summarize();
   end
endmodule // testbench
